// ==== design/thermal_defs.svh ====
// register offsets, field positions and reset values of the thermal event monitor
// assumes one clock domain and a single-word register access port
//
// Summary of operation
// - rising over-warning comparator sets the thermal warning flag
// - rising over-shutdown comparator sets shutdown flag and raises the shutdown request
// - after shutdown, restart stays blocked until the die reads below restart level
// - warning flag is bit 2, shutdown flag bit 1 of status at 1Ah; edge set
// - a read of the status register clears its thermal flags
// - mask bits 2:1 at 22h block matching flags when 1; reset 0
// - unmasked system flags combine into the first-level system summary bit
`ifndef THERMAL_DEFS_SVH
`define THERMAL_DEFS_SVH

`define REG_ADDR_W              8
`define REG_DATA_W              16

// register offsets
`define OFS_FIRST_SUMMARY       8'h18
`define OFS_SECOND_STATUS       8'h1a
`define OFS_FIRST_MASK          8'h20
`define OFS_SECOND_MASK         8'h22

// field positions
`define BIT_WARNING             1
`define BIT_SHUTDOWN            1
`define POS_WARNING             2
`define POS_SHUTDOWN            1
`define POS_SYSTEM_SUMMARY      3
`define FIRST_MASK_W            14

// reset values
`define RST_FIRST_SUMMARY       16'h0000
`define RST_SECOND_STATUS       16'h0000
`define RST_FIRST_MASK          14'h3fff
`define RST_SECOND_MASK         2'h0

`endif

// ==== design/thermal_pkg.sv ====
// types shared by the thermal event monitor
// assumes thermal_defs.svh is on the include path
`include "thermal_defs.svh"

package thermal_pkg;

    // comparator levels from the analog sensor, synchronous to clk
    typedef struct packed {
        logic over_warning;     // die above warning level
        logic over_shutdown;    // die above shutdown level
        logic below_restart;    // die cooled below restart level
    } thermal_sense_type;

    // one register access from the control interface
    typedef struct packed {
        logic                   rd;
        logic                   wr;
        logic [`REG_ADDR_W-1:0] addr;
        logic [`REG_DATA_W-1:0] wdata;
    } reg_req_type;

    // power state, gray coded along run -> shutdown -> cooled; cooled -> run flips both bits
    typedef enum logic [1:0] {
        st_run      = 2'b00,
        st_shutdown = 2'b01,
        st_cooled   = 2'b11
    } power_state_type;

endpackage

// ==== design/thermal_event_monitor.sv ====
// thermal event monitor: edge-captured warning and shutdown flags, masks,
// first-level summary, shutdown request and restart interlock
// assumes sensor levels and register accesses are synchronous to clk
`timescale 1ns/1ps
`include "thermal_defs.svh"

module thermal_event_monitor
    import thermal_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // sensor comparators and power control
    input  wire thermal_sense_type      sense,
    input  wire logic                   restart_req,
    output logic                        shutdown_req_r,
    output logic                        restart_ok_r,
    // register access
    input  wire reg_req_type            req,
    output logic [`REG_DATA_W-1:0]      reg_rdata_r,
    output logic                        reg_rvalid_r,
    // interrupt request to the host
    output logic                        irq_req_r
);

    // edge detection
    logic                       warn_prev_r;
    logic                       shut_prev_r;
    logic                       warn_rise;
    logic                       shut_rise;
    // event flags and masks
    logic                       warning_flag_r;
    logic                       shutdown_flag_r;
    logic [1:0]                 second_mask_r;
    logic [`FIRST_MASK_W-1:0]   first_mask_r;
    // summary, state and read path
    logic                       summary_r;
    logic                       status_read;
    logic                       summary_nxt;
    logic [`REG_DATA_W-1:0]     rdata_nxt;
    power_state_type            state_r;

    // reset words kept whole so single bits can be picked out of them
    localparam logic [`REG_DATA_W-1:0] RST_STATUS_WORD  = `RST_SECOND_STATUS;
    localparam logic [`REG_DATA_W-1:0] RST_SUMMARY_WORD = `RST_FIRST_SUMMARY;

    // previous warning comparator level for edge detection;
    // a comparator already high when reset ends counts as a fresh edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            warn_prev_r <= 1'b0;
        end else begin
            warn_prev_r <= sense.over_warning;
        end
    end

    // previous shutdown comparator level for edge detection
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shut_prev_r <= 1'b0;
        end else begin
            shut_prev_r <= sense.over_shutdown;
        end
    end

    // rising edges of the comparator levels
    assign warn_rise   = sense.over_warning & ~warn_prev_r;
    assign shut_rise   = sense.over_shutdown & ~shut_prev_r;
    assign status_read = req.rd && (req.addr == `OFS_SECOND_STATUS);

    // warning flag: a new edge wins over the clearing read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            warning_flag_r <= RST_STATUS_WORD[`POS_WARNING];
        end else if (warn_rise) begin
            warning_flag_r <= 1'b1;
        end else if (status_read) begin
            warning_flag_r <= 1'b0;
        end
    end

    // shutdown flag: a new edge wins over the clearing read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shutdown_flag_r <= RST_STATUS_WORD[`POS_SHUTDOWN];
        end else if (shut_rise) begin
            shutdown_flag_r <= 1'b1;
        end else if (status_read) begin
            shutdown_flag_r <= 1'b0;
        end
    end

    // second-level mask, bits 2:1 of its word; writes to 18h and 1Ah are dropped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            second_mask_r <= `RST_SECOND_MASK;
        end else if (req.wr && (req.addr == `OFS_SECOND_MASK)) begin
            second_mask_r <= req.wdata[`POS_WARNING:`POS_SHUTDOWN];
        end
    end

    // first-level mask; its reset value keeps the request line quiet
    // until software opens it, so a stale flag cannot interrupt at power-up
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_mask_r <= `RST_FIRST_MASK;
        end else if (req.wr && (req.addr == `OFS_FIRST_MASK)) begin
            first_mask_r <= req.wdata[`FIRST_MASK_W-1:0];
        end
    end

    // summary from unmasked flags; masked flags never reach it
    always_comb begin
        summary_nxt = (warning_flag_r & ~second_mask_r[`POS_WARNING-`POS_SHUTDOWN])
                    | (shutdown_flag_r & ~second_mask_r[0]);
    end

    // summary bit follows the unmasked flags one cycle later
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            summary_r <= RST_SUMMARY_WORD[`POS_SYSTEM_SUMMARY];
        end else begin
            summary_r <= summary_nxt;
        end
    end

    // interrupt request; the first-level mask gates the line only,
    // so software can still poll the summary bit while it is masked
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req_r <= 1'b0;
        end else begin
            irq_req_r <= summary_nxt & ~first_mask_r[`POS_SYSTEM_SUMMARY];
        end
    end

    // power state: shutdown on the over-shutdown edge, restart only once cooled
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= st_run;
        end else begin
            unique case (state_r)
                st_run: begin
                    if (shut_rise) begin
                        state_r <= st_shutdown;
                    end
                end
                // stays down whatever software reads; only cooling moves it on
                st_shutdown: begin
                    if (sense.below_restart) begin
                        state_r <= st_cooled;
                    end
                end
                // a new over-shutdown edge or a warm-up sends it back down
                st_cooled: begin
                    if (shut_rise || !sense.below_restart) begin
                        state_r <= st_shutdown;
                    end else if (restart_req) begin
                        state_r <= st_run;
                    end
                end
                default: begin
                    state_r <= st_shutdown;                     // illegal code fails safe
                end
            endcase
        end
    end

    // shutdown request stands in every state but run, one cycle behind it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shutdown_req_r <= 1'b0;
        end else begin
            shutdown_req_r <= (state_r != st_run);
        end
    end

    // restart permit, one cycle behind the cooled state in which restart_req is taken
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            restart_ok_r <= 1'b0;
        end else begin
            restart_ok_r <= (state_r == st_cooled);
        end
    end

    // read data mux; unmapped addresses and reserved bits read zero
    // the flags shown are those before a clearing read takes effect
    always_comb begin
        rdata_nxt = '0;
        unique case (req.addr)
            `OFS_FIRST_SUMMARY: begin
                rdata_nxt[`POS_SYSTEM_SUMMARY] = summary_r;
            end
            `OFS_SECOND_STATUS: begin
                rdata_nxt[`POS_WARNING]  = warning_flag_r;
                rdata_nxt[`POS_SHUTDOWN] = shutdown_flag_r;
            end
            `OFS_FIRST_MASK: begin
                rdata_nxt[`FIRST_MASK_W-1:0] = first_mask_r;
            end
            `OFS_SECOND_MASK: begin
                rdata_nxt[`POS_WARNING:`POS_SHUTDOWN] = second_mask_r;
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    // read answer one cycle after the request
    // read data holds between reads so a slow host can pick it up late
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r  <= '0;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= req.rd;
            if (req.rd) begin
                reg_rdata_r <= rdata_nxt;
            end
        end
    end

endmodule // thermal_event_monitor

// ==== sim/thermal_sensor_model.sv ====
// sensor comparator model facing the monitor
// assumes the testbench sets the die temperature in whole degrees
`timescale 1ns/1ps
module thermal_sensor_model
    import thermal_pkg::*;
#(
    parameter int WARN_C    = 115,
    parameter int SHUT_C    = 140,
    parameter int RESTART_C = 100  // plain default level
)(
    // die temperature in
    input  wire logic [7:0]        temp_c,
    // comparator levels out
    output wire thermal_sense_type sense
);
    // comparators follow the temperature
    assign sense = '{over_warning:  (int'(temp_c) > WARN_C),
                     over_shutdown: (int'(temp_c) > SHUT_C),
                     below_restart: (int'(temp_c) < RESTART_C)};
endmodule // thermal_sensor_model

// ==== sim/thermal_event_monitor_assertions.sv ====
// port checker of the thermal event monitor
// assumes it is bound to the monitor from the testbench
`timescale 1ns/1ps
`include "thermal_defs.svh"
module thermal_event_monitor_checker
    import thermal_pkg::*;
(
    // clock and reset
    input wire logic                   clk,
    input wire logic                   sys_rst,
    // sensor and power
    input wire thermal_sense_type      sense,
    input wire logic                   restart_req,
    input wire logic                   shutdown_req_r,
    input wire logic                   restart_ok_r,
    // registers and interrupt
    input wire reg_req_type            req,
    input wire logic [`REG_DATA_W-1:0] reg_rdata_r,
    input wire logic                   reg_rvalid_r,
    input wire logic                   irq_req_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // status read strobe
    wire st_rd = req.rd && req.addr == 8'h1a;
    // masks both thermal flags
    wire mask_all = req.wr && req.addr == 8'h22 && req.wdata[2:1] == 2'b11;
    a_read_answer: assert property (
        req.rd ##1 !req.rd |-> reg_rvalid_r ##1 !reg_rvalid_r)
        else $error("read answer not one cycle");
    a_warn_latch: assert property (
        $rose(sense.over_warning) ##1 st_rd |=> reg_rdata_r[2])
        else $error("warning flag not latched");
    a_shut_latch: assert property (
        $rose(sense.over_shutdown) ##1 st_rd |=> reg_rdata_r[1])
        else $error("shutdown flag not latched");
    a_shut_request: assert property (
        $rose(sense.over_shutdown) |-> ##[1:2] shutdown_req_r)
        else $error("no shutdown request");
    a_cool_first: assert property (
        $rose(restart_ok_r) |-> $past(sense.below_restart, 2))
        else $error("restart allowed while hot");
    a_hold_down: assert property (
        $fell(shutdown_req_r) |-> $past(restart_ok_r))
        else $error("left shutdown without restart permit");
    a_read_clears: assert property (
        st_rd && $stable(sense) ##1 $stable(sense) ##1 st_rd |=> reg_rdata_r[2:1] == 2'b00)
        else $error("flags survive a read");
    a_status_spare: assert property (
        st_rd |=> (reg_rdata_r & 16'hfff9) == 16'h0000)
        else $error("status spare bits set");
    a_masked_quiet: assert property (
        mask_all ##1 (!req.wr)[*3] |=> !irq_req_r)
        else $error("masked flags raise interrupt");
    // main scenarios
    c_irq: cover property ($rose(irq_req_r));
    c_restart_ok: cover property ($rose(restart_ok_r));
    c_restart: cover property ($fell(shutdown_req_r));
endmodule // thermal_event_monitor_checker

// ==== sim/tb_thermal_event_monitor.sv ====
// testbench of the thermal event monitor through its strobe register port
// assumes design, package, sensor model and checker compiled before it
`timescale 1ns/1ps
module tb_thermal_event_monitor;
    import thermal_pkg::*;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              restart_req = 1'b0;
    logic [7:0]        temp_c = 8'd25;
    reg_req_type       req = '0;
    thermal_sense_type sense;
    logic [15:0]       reg_rdata_r;
    logic              shutdown_req_r, restart_ok_r, reg_rvalid_r, irq_req_r;
    int                fail_count = 0;
    int                check_count = 0;
    // clock and parts
    always #2 clk = ~clk;
    thermal_sensor_model sensor (.temp_c(temp_c), .sense(sense));
    thermal_event_monitor dut (.clk(clk), .sys_rst(sys_rst), .sense(sense),
        .restart_req(restart_req), .shutdown_req_r(shutdown_req_r),
        .restart_ok_r(restart_ok_r), .req(req), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .irq_req_r(irq_req_r));
    // compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // wait n edges, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // register read with checked answer
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk) #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge clk) #1 req.rd = 1'b0;
        chk(16'(reg_rvalid_r), 16'h0001);
        chk(reg_rdata_r, exp);
    endtask
    // register write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk) #1 req.wr = 1'b0;
    endtask
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
    // test sequence
    initial begin
        wt(16);
        sys_rst = 1'b0;
        wr(8'h18, 16'hffff);
        rd(8'h18, 16'h0000);
        rd(8'h1a, 16'h0000);
        rd(8'h20, 16'h3fff);
        rd(8'h22, 16'h0000);
        rd(8'h30, 16'h0000);
        $display("test reset done");
        temp_c = 8'd120;
        rd(8'h1a, 16'h0004);
        rd(8'h1a, 16'h0000);
        $display("test warning done");
        wr(8'h20, 16'h0000);
        wr(8'h22, 16'h0006);
        rd(8'h22, 16'h0006);
        temp_c = 8'd145;
        wt(4);
        chk(16'(shutdown_req_r), 16'h0001);
        chk(16'(irq_req_r), 16'h0000);
        rd(8'h18, 16'h0000);
        restart_req = 1'b1;
        wt(3);
        restart_req = 1'b0;
        chk(16'(shutdown_req_r), 16'h0001);
        chk(16'(restart_ok_r), 16'h0000);
        wr(8'h22, 16'h0000);
        wt(3);
        chk(16'(irq_req_r), 16'h0001);
        rd(8'h18, 16'h0008);
        rd(8'h1a, 16'h0002);
        wt(3);
        chk(16'(irq_req_r), 16'h0000);
        temp_c = 8'd130;
        wt(1);
        temp_c = 8'd145;
        rd(8'h1a, 16'h0002);
        $display("test shutdown done");
        temp_c = 8'd90;
        wt(4);
        chk(16'(restart_ok_r), 16'h0001);
        restart_req = 1'b1;
        wt(1);
        restart_req = 1'b0;
        wt(3);
        chk(16'(shutdown_req_r), 16'h0000);
        $display("test restart done");
        // mask only the shutdown flag; the warning still interrupts
        wr(8'h22, 16'h0002);
        temp_c = 8'd120;
        wt(3);
        chk(16'(irq_req_r), 16'h0001);
        rd(8'h1a, 16'h0004);
        temp_c = 8'd145;
        wt(4);
        chk(16'(shutdown_req_r), 16'h0001);
        chk(16'(irq_req_r), 16'h0000);
        rd(8'h1a, 16'h0002);
        $display("test single mask done");
        // cooled, then warm again: back to shutdown, restart refused
        temp_c = 8'd90;
        wt(3);
        chk(16'(restart_ok_r), 16'h0001);
        temp_c = 8'd105;
        restart_req = 1'b1;
        wt(3);
        restart_req = 1'b0;
        chk(16'(restart_ok_r), 16'h0000);
        chk(16'(shutdown_req_r), 16'h0001);
        $display("test cooled fallback done");
        // reset in mid-run brings back the default masks
        sys_rst = 1'b1;
        wt(2);
        sys_rst = 1'b0;
        chk(16'(shutdown_req_r), 16'h0000);
        rd(8'h20, 16'h3fff);
        rd(8'h22, 16'h0000);
        rd(8'h1a, 16'h0000);
        temp_c = 8'd120;
        wt(3);
        chk(16'(irq_req_r), 16'h0000);
        rd(8'h18, 16'h0008);
        rd(8'h1a, 16'h0004);
        $display("test reset in run done");
        complete_run();
    end
endmodule // tb_thermal_event_monitor
bind thermal_event_monitor thermal_event_monitor_checker chk_i (.clk(clk), .sys_rst(sys_rst),
    .sense(sense), .restart_req(restart_req), .shutdown_req_r(shutdown_req_r),
    .restart_ok_r(restart_ok_r), .req(req), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .irq_req_r(irq_req_r));
